//--- hdl/wsc_pkg.sv
// Purpose: Shared constants and types for the watchdog and sleep controller
// Assumes: AHB-Lite register access, 50 MHz system clock
// Notes: Register offsets are byte addresses (index times four)
package wsc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] WSC_OPTION_IDX = 16'h0081;
   localparam logic [15:0] WSC_CONFIG_IDX = 16'h2007;
   localparam logic [17:0] WSC_OPTION_ADDR = {WSC_OPTION_IDX, 2'b00};
   localparam logic [17:0] WSC_CONFIG_ADDR = {WSC_CONFIG_IDX, 2'b00};
   localparam logic [17:0] WSC_STATUS_ADDR = 18'h0_0300;
   localparam logic [17:0] WSC_CTRL_ADDR = 18'h0_0304;
   localparam logic [17:0] WSC_INTEN_ADDR = 18'h0_0308;
   localparam logic [17:0] WSC_INTFLG_ADDR = 18'h0_030C;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int WSC_WDT_EN_BIT = 2;
   localparam int WSC_ASSIGN_BIT = 3;
   localparam int WSC_POWERDOWN_BIT = 3;
   localparam int WSC_TO_BIT = 4;
   localparam int WSC_GLOBAL_EN_BIT = 7;
   localparam logic [7:0] WSC_OPTION_RST = 8'hFF;
   localparam logic [7:0] WSC_CONFIG_RST = 8'hFF;
   localparam int WSC_NSRC = 8;
   localparam logic [15:0] WSC_INT_VECTOR = 16'h0004;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int WSC_CLK_MHZ = 50;
   localparam int WSC_WDT_BITS = 8;
   localparam int WSC_OSC_START_US = 2;
   localparam int WSC_OSC_START_CYC = WSC_OSC_START_US * WSC_CLK_MHZ;

   typedef enum logic [1:0] {
      WSC_RUN = 2'b00,
      WSC_SLEEP = 2'b01,
      WSC_WAKE = 2'b10
   } wsc_mode_type;

   typedef struct packed {
      logic clear_watchdog;
      logic sleep;
   } wsc_cmd_type;

endpackage : wsc_pkg

//--- hdl/wsc_watchdog_sleep.sv
// Purpose: Watchdog, shared divider and sleep/wake control
// Assumes: WDT_OSC is a slow free-running RC clock sampled through
//          two flops; core pulses are one CLK_SYS cycle
// Notes: Overview of operation follows
//
// Overview of operation
// - Watchdog counts edges of its own RC oscillator, also during sleep.
// - Time-out while running issues a watchdog device reset.
// - Time-out while asleep wakes the device instead of resetting.
// - A time-out in sleep, or in run without a same-cycle clear-watchdog or taken sleep, clears the time-out flag; one during wake is ignored.
// - Cleared config enable bit disables watchdog; software cannot override.
// - Shared divider assigned to watchdog by option bit 3, ratio bits.
// - Clear-watchdog or sleep zero the counter and assigned divider.
// - Clear-watchdog leaves divider assignment setting untouched.
// - Sleep clears watchdog, clears power-down flag, sets time-out flag.
// - Pins hold their pre-sleep drive state during sleep.
// - Wake on master clear (reset), watchdog or enabled interrupt.
// - Power-down flag set at power-up, cleared only by sleep.
// - Only clockless peripheral interrupts may wake the device.
// - Next instruction prefetched; wake needs own enable, not global.
// - After wake run prefetched instruction, then vector if global set.
// - Pending enabled interrupt makes sleep a no-operation.
// - Interrupt during sleep: sleep completes, then wakes immediately.
// - Interrupt flags set regardless of enables.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module wsc_watchdog_sleep
   import wsc_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic WDT_OSC,
   input wire logic MASTER_CLEAR_N,
   input wire logic CLEAR_WATCHDOG_INSTRUCTION,
   input wire logic SLEEP_INSTRUCTION,
   input wire logic [WSC_NSRC-1:0] INT_EVENT,
   input wire logic [WSC_NSRC-1:0] CLOCKLESS_SOURCE,
   input wire logic [7:0] PIN_OUT_REQ,
   input wire logic [7:0] PIN_OE_N_REQ,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic WATCHDOG_RESET,
   output logic DEVICE_RESET,
   output logic OSC_DRIVER_ON,
   output logic CORE_HOLD,
   output logic PREFETCH_EXEC,
   output logic VECTOR_BRANCH,
   output logic [15:0] VECTOR_ADDR,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE_N
);

   typedef struct packed {
      logic [1:0] osc_sync;
      logic osc_prev;
      logic [1:0] clear_pin_sync;
      logic [WSC_WDT_BITS-1:0] wdt;
      logic [7:0] divider;
      logic [7:0] option;
      logic [7:0] config_word;
      logic [7:0] int_en;
      logic [7:0] int_flag;
      logic global_interrupt_enable;
      logic timeout_status_flag_n;
      logic powerdown_status_flag_n;
      wsc_mode_type mode;
      logic [7:0] start_cnt;
      logic wd_reset;
      logic dev_reset;
      logic osc_on;
      logic hold;
      logic prefetch;
      logic vector;
      logic [7:0] pin_out;
      logic [7:0] pin_oe_n;
      logic ph_valid;
      logic ph_write;
      logic [17:0] ph_addr;
      logic [31:0] rdata;
   } wsc_state_type;

   wsc_state_type r;
   wsc_state_type next_r;

   logic osc_rise;
   logic div_out;
   logic tick;
   logic timeout;
   logic pending;
   logic any_enabled;
   logic [7:0] ratio_mask;

   always_comb begin
      next_r = r;
      osc_rise = r.osc_sync[1] & ~r.osc_prev;
      ratio_mask = 8'(({1'b0, 8'h01} << r.option[2:0]) - 9'h001);
      next_r.osc_sync = {r.osc_sync[0], WDT_OSC};
      next_r.clear_pin_sync = {r.clear_pin_sync[0], MASTER_CLEAR_N};
      next_r.osc_prev = r.osc_sync[1];
      next_r.wd_reset = 1'b0;
      next_r.dev_reset = 1'b0;
      next_r.prefetch = 1'b0;
      next_r.vector = 1'b0;
      pending = |(r.int_flag & r.int_en & CLOCKLESS_SOURCE);
      any_enabled = |(r.int_flag & r.int_en);

      // ----------------------------------------------------------------
      // Watchdog counter and shared divider
      // ----------------------------------------------------------------
      div_out = 1'b0;
      tick = 1'b0;
      timeout = 1'b0;
      if (r.config_word[WSC_WDT_EN_BIT] && osc_rise) begin
         next_r.wdt = r.wdt + 1'b1;
         if (&r.wdt) begin
            tick = 1'b1;
         end
      end
      if (tick) begin
         if (r.option[WSC_ASSIGN_BIT]) begin
            next_r.divider = (r.divider + 8'h01) & ratio_mask;
            div_out = (r.divider == ratio_mask);
         end else begin
            div_out = 1'b1;
         end
      end
      timeout = div_out;

      // ----------------------------------------------------------------
      // Interrupt flags
      // ----------------------------------------------------------------
      next_r.int_flag = r.int_flag | INT_EVENT;

      // ----------------------------------------------------------------
      // Register bus
      // ----------------------------------------------------------------
      next_r.ph_valid = HSEL & HREADY & HTRANS[1];
      next_r.ph_write = HWRITE;
      next_r.ph_addr = HADDR[17:0];
      if (r.ph_valid && r.ph_write) begin
         if (r.ph_addr == WSC_OPTION_ADDR) begin
            next_r.option = HWDATA[7:0];
         end else if (r.ph_addr == WSC_INTEN_ADDR) begin
            next_r.int_en = HWDATA[7:0];
         end else if (r.ph_addr == WSC_INTFLG_ADDR) begin
            next_r.int_flag = (r.int_flag & ~HWDATA[7:0]) | INT_EVENT;
         end else if (r.ph_addr == WSC_CTRL_ADDR) begin
            next_r.global_interrupt_enable = HWDATA[WSC_GLOBAL_EN_BIT];
         end
      end
      next_r.rdata = 32'h0000_0000;
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
         if (HADDR[17:0] == WSC_OPTION_ADDR) begin
            next_r.rdata = {24'h00_0000, next_r.option};
         end else if (HADDR[17:0] == WSC_CONFIG_ADDR) begin
            next_r.rdata = {24'h00_0000, r.config_word};
         end else if (HADDR[17:0] == WSC_STATUS_ADDR) begin
            next_r.rdata = {27'h000_0000, r.timeout_status_flag_n,
               r.powerdown_status_flag_n, 1'b0, r.mode};
         end else if (HADDR[17:0] == WSC_CTRL_ADDR) begin
            next_r.rdata = {24'h00_0000, r.global_interrupt_enable, 7'h00};
         end else if (HADDR[17:0] == WSC_INTEN_ADDR) begin
            next_r.rdata = {24'h00_0000, r.int_en};
         end else if (HADDR[17:0] == WSC_INTFLG_ADDR) begin
            next_r.rdata = {24'h00_0000, r.int_flag};
         end
      end

      // ----------------------------------------------------------------
      // Instructions and power modes
      // ----------------------------------------------------------------
      case (r.mode)
         WSC_RUN: begin
            if (CLEAR_WATCHDOG_INSTRUCTION) begin
               next_r.wdt = '0;
               if (r.option[WSC_ASSIGN_BIT]) begin
                  next_r.divider = 8'h00;
               end
               next_r.timeout_status_flag_n = 1'b1;
               next_r.powerdown_status_flag_n = 1'b1;
            end else if (SLEEP_INSTRUCTION && !any_enabled) begin
               next_r.wdt = '0;
               if (r.option[WSC_ASSIGN_BIT]) begin
                  next_r.divider = 8'h00;
               end
               next_r.powerdown_status_flag_n = 1'b0;
               next_r.timeout_status_flag_n = 1'b1;
               next_r.osc_on = 1'b0;
               next_r.hold = 1'b1;
               next_r.pin_out = r.pin_out;
               next_r.pin_oe_n = r.pin_oe_n;
               next_r.mode = WSC_SLEEP;
            end else if (timeout) begin
               next_r.timeout_status_flag_n = 1'b0;
               next_r.wd_reset = 1'b1;
               next_r.dev_reset = 1'b1;
            end
            if (r.mode == WSC_RUN && next_r.mode == WSC_RUN) begin
               next_r.pin_out = PIN_OUT_REQ;
               next_r.pin_oe_n = PIN_OE_N_REQ;
            end
         end
         WSC_SLEEP: begin
            if (timeout || pending) begin
               if (timeout) begin
                  next_r.timeout_status_flag_n = 1'b0;
               end
               next_r.osc_on = 1'b1;
               next_r.start_cnt = 8'(WSC_OSC_START_CYC - 1);
               next_r.mode = WSC_WAKE;
            end
         end
         WSC_WAKE: begin
            if (r.start_cnt == 8'h00) begin
               next_r.hold = 1'b0;
               next_r.prefetch = 1'b1;
               next_r.vector = r.global_interrupt_enable & pending;
               next_r.mode = WSC_RUN;
            end else begin
               next_r.start_cnt = r.start_cnt - 8'h01;
            end
         end
         default: begin
            next_r.mode = WSC_RUN;
         end
      endcase

      // Master clear always resets, even asleep
      if (!r.clear_pin_sync[1]) begin
         next_r.dev_reset = 1'b1;
         next_r.mode = WSC_RUN;
         next_r.osc_on = 1'b1;
         next_r.hold = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         r <= '0;
         r.osc_sync <= 2'b00;
         r.clear_pin_sync <= 2'b11;
         r.option <= WSC_OPTION_RST;
         r.config_word <= WSC_CONFIG_RST;
         r.timeout_status_flag_n <= 1'b1;
         r.powerdown_status_flag_n <= 1'b1;
         r.mode <= WSC_RUN;
         r.osc_on <= 1'b1;
         r.pin_oe_n <= 8'hFF;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign HRDATA = r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign WATCHDOG_RESET = r.wd_reset;
   assign DEVICE_RESET = r.dev_reset;
   assign OSC_DRIVER_ON = r.osc_on;
   assign CORE_HOLD = r.hold;
   assign PREFETCH_EXEC = r.prefetch;
   assign VECTOR_BRANCH = r.vector;
   assign VECTOR_ADDR = WSC_INT_VECTOR;
   assign PIN_OUT = r.pin_out;
   assign PIN_OE_N = r.pin_oe_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence sleep_taken_s;
      r.mode == WSC_RUN && SLEEP_INSTRUCTION && !CLEAR_WATCHDOG_INSTRUCTION
         && !any_enabled && r.clear_pin_sync[1];
   endsequence

   sequence wake_start_s;
      r.mode == WSC_SLEEP && pending && r.clear_pin_sync[1];
   endsequence

   sleep_entry_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      sleep_taken_s |=> !r.powerdown_status_flag_n && r.timeout_status_flag_n
         && !OSC_DRIVER_ON && r.wdt == '0)
      else $error("sleep entry side effects missing");

   sleep_nop_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      r.mode == WSC_RUN && SLEEP_INSTRUCTION && any_enabled
         && !CLEAR_WATCHDOG_INSTRUCTION && r.clear_pin_sync[1]
         |=> r.mode == WSC_RUN && $stable(r.powerdown_status_flag_n))
      else $error("sleep not a no-op with pending interrupt");

   wd_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      WATCHDOG_RESET |-> DEVICE_RESET && !r.timeout_status_flag_n)
      else $error("watchdog reset without reset or flag");

   wd_disable_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !r.config_word[WSC_WDT_EN_BIT] |=> !WATCHDOG_RESET)
      else $error("disabled watchdog fired");

   wake_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wake_start_s
         |=> OSC_DRIVER_ON && CORE_HOLD ##[1:120] PREFETCH_EXEC)
      else $error("wake did not resume");

   pins_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      r.mode == WSC_SLEEP |=> $stable(PIN_OUT) && $stable(PIN_OE_N))
      else $error("pins changed while asleep");

   vector_enable_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      VECTOR_BRANCH |-> PREFETCH_EXEC && r.global_interrupt_enable)
      else $error("vector without prefetch or global enable");

   sleep_wd_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      r.mode == WSC_SLEEP && timeout && r.clear_pin_sync[1]
         |=> !WATCHDOG_RESET && r.mode == WSC_WAKE)
      else $error("sleep time-out did not wake");

   clear_zeroes_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      r.mode == WSC_RUN && CLEAR_WATCHDOG_INSTRUCTION
         |=> r.wdt == '0 && r.timeout_status_flag_n
         && (r.divider == '0 || !$past(r.option[WSC_ASSIGN_BIT])))
      else $error("clear-watchdog left counter running");

   pin_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !r.clear_pin_sync[1] |=> DEVICE_RESET && r.mode == WSC_RUN)
      else $error("master clear did not reset");

   sleep_only_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $fell(r.powerdown_status_flag_n)
         |-> $past(SLEEP_INSTRUCTION))
      else $error("power-down flag cleared without sleep");

endmodule : wsc_watchdog_sleep
`default_nettype wire

//--- verification/wsc_core_model.sv
// Purpose: Core model issuing clear-watchdog and sleep pulses
// Assumes: Bench requests are one-cycle levels
// Notes: Master clear kept released while the core is held
`timescale 1ns/1ps
`default_nettype none
module wsc_core_model
   import wsc_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire wsc_cmd_type CMD_REQ,
   input wire logic MASTER_CLEAR_REQ_N,
   input wire logic CORE_HOLD,
   output logic CLEAR_WATCHDOG_INSTRUCTION,
   output logic SLEEP_INSTRUCTION,
   output logic MASTER_CLEAR_N
);
   // ----------------------------------------------------------------
   // Instruction pulses
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         CLEAR_WATCHDOG_INSTRUCTION <= 1'h0;
         SLEEP_INSTRUCTION <= 1'h0;
      end else begin
         // A held core executes nothing
         CLEAR_WATCHDOG_INSTRUCTION <= CMD_REQ.clear_watchdog & ~CORE_HOLD;
         SLEEP_INSTRUCTION <= CMD_REQ.sleep & ~CORE_HOLD;
      end
   end
   assign MASTER_CLEAR_N = MASTER_CLEAR_REQ_N | CORE_HOLD;
endmodule : wsc_core_model
`default_nettype wire

//--- verification/watchdog_sleep_wake_control_tb.sv
// Purpose: Self-checking bench for the watchdog and sleep controller
// Assumes: Registers reached over AHB-Lite, one slave
// Notes: Watchdog RC clock runs at 5 MHz, unrelated in phase
`timescale 1ns/1ps
`default_nettype none
module watchdog_sleep_wake_control_tb import wsc_pkg::*;;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam wsc_cmd_type SLP = 2'h1;
   localparam wsc_cmd_type CLR = 2'h2;
   logic CLK_SYS, RESET_N, WDT_OSC, MASTER_CLEAR_REQ_N, MASTER_CLEAR_N;
   logic CLEAR_WATCHDOG_INSTRUCTION, SLEEP_INSTRUCTION;
   logic [7:0] INT_EVENT, CLOCKLESS_SOURCE, PIN_OUT_REQ, PIN_OE_N_REQ;
   logic HSEL, HWRITE, HREADYOUT, HRESP;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic WATCHDOG_RESET, DEVICE_RESET, OSC_DRIVER_ON, CORE_HOLD;
   logic PREFETCH_EXEC, VECTOR_BRANCH, got, vb;
   logic [15:0] VECTOR_ADDR;
   logic [7:0] PIN_OUT, PIN_OE_N;
   wsc_cmd_type CMD_REQ;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_wdr = 0;
   int n0;
   wire logic HREADY;
   assign HREADY = HREADYOUT;

   wsc_watchdog_sleep wsc_watchdog_sleep_inst (
      .CLK_SYS, .RESET_N, .WDT_OSC, .MASTER_CLEAR_N,
      .CLEAR_WATCHDOG_INSTRUCTION, .SLEEP_INSTRUCTION, .INT_EVENT,
      .CLOCKLESS_SOURCE, .PIN_OUT_REQ, .PIN_OE_N_REQ, .HSEL, .HADDR,
      .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
      .HRESP, .WATCHDOG_RESET, .DEVICE_RESET, .OSC_DRIVER_ON, .CORE_HOLD,
      .PREFETCH_EXEC, .VECTOR_BRANCH, .VECTOR_ADDR, .PIN_OUT, .PIN_OE_N
   );
   wsc_core_model wsc_core_model_inst (
      .CLK_SYS, .RESET_N, .CMD_REQ, .MASTER_CLEAR_REQ_N, .CORE_HOLD,
      .CLEAR_WATCHDOG_INSTRUCTION, .SLEEP_INSTRUCTION, .MASTER_CLEAR_N
   );

   initial begin
      CLK_SYS = 1'h0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      WDT_OSC = 1'h0;
      #3;
      forever #100 WDT_OSC = ~WDT_OSC;
   end
   always @(posedge CLK_SYS) begin
      if (WATCHDOG_RESET === 1'h1) n_wdr++;
   end
   initial begin
      #400_000;
      n_mismatch++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
      comparisons++;
      if (gv !== ev) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, gv, ev);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [17:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge CLK_SYS);
      HSEL <= 1'h1;
      HTRANS <= 2'h2;
      HADDR <= {14'h0, a};
      HWRITE <= w;
      @(posedge CLK_SYS);
      while (HREADYOUT !== 1'h1) @(posedge CLK_SYS);
      HSEL <= 1'h0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CLK_SYS);
      while (HREADYOUT !== 1'h1) @(posedge CLK_SYS);
      rd = HRDATA;
   endtask : bus

   task automatic wr(input logic [17:0] a, input logic [31:0] dv);
      logic [31:0] r;
      bus(1'h1, a, dv, r);
   endtask : wr

   task automatic rdc(input logic [17:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] r;
      bus(1'h0, a, 32'h0, r);
      chk(r & m, e);
   endtask : rdc

   // Event pulse lands on the same edge as the instruction
   task automatic core(input wsc_cmd_type c, input logic [7:0] e);
      @(posedge CLK_SYS);
      CMD_REQ <= c;
      @(posedge CLK_SYS);
      CMD_REQ <= '0;
      INT_EVENT <= e;
      @(posedge CLK_SYS);
      INT_EVENT <= '0;
      repeat (3) @(posedge CLK_SYS);
   endtask : core

   task automatic wake(input int lim);
      got = 1'h0;
      vb = 1'h0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge CLK_SYS);
         got = (PREFETCH_EXEC === 1'h1);
         vb = VECTOR_BRANCH;
      end
   endtask : wake
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      RESET_N = 1'h0;
      MASTER_CLEAR_REQ_N = 1'h1;
      CMD_REQ = '0;
      INT_EVENT = '0;
      CLOCKLESS_SOURCE = 8'h01;
      PIN_OUT_REQ = 8'h5A;
      PIN_OE_N_REQ = 8'h0F;
      HSEL = 1'h0;
      HADDR = '0;
      HTRANS = '0;
      HWRITE = 1'h0;
      HSIZE = 3'h2;
      HWDATA = '0;
      repeat (16) @(posedge CLK_SYS);
      RESET_N <= 1'h1;
      rdc(WSC_OPTION_ADDR, 32'hFF, 32'hFF);
      chk(32'(HRESP), 32'h0);
      rdc(WSC_STATUS_ADDR, 32'h1B, 32'h18);
      wr(WSC_CONFIG_ADDR, 32'h0);
      rdc(WSC_CONFIG_ADDR, 32'hFF, 32'hFF);
      rdc(18'h0_0400, 32'hFFFF_FFFF, 32'h0);
      wr(WSC_CTRL_ADDR, 32'h80);
      wr(WSC_INTEN_ADDR, 32'h01);
      wr(WSC_INTFLG_ADDR, 32'hFF);
      core(SLP, 8'h00);
      chk(32'(OSC_DRIVER_ON), 32'h0);
      rdc(WSC_STATUS_ADDR, 32'h1B, 32'h11);
      PIN_OUT_REQ <= 8'hA5;
      PIN_OE_N_REQ <= 8'hF0;
      repeat (3) @(posedge CLK_SYS);
      chk({PIN_OUT, PIN_OE_N}, 32'h5A0F);
      core('0, 8'h01);
      chk({CORE_HOLD, OSC_DRIVER_ON}, 32'h3);
      wake(400);
      chk({got, vb}, 32'h3);
      chk({16'h0, VECTOR_ADDR}, 32'h4);
      repeat (2) @(posedge CLK_SYS);
      chk({CORE_HOLD, PIN_OUT}, 32'hA5);
      wr(WSC_CTRL_ADDR, 32'h0);
      wr(WSC_INTEN_ADDR, 32'h03);
      wr(WSC_INTFLG_ADDR, 32'hFF);
      core(SLP, 8'h00);
      core('0, 8'h02);
      wake(300);
      chk(32'(got), 32'h0);
      core('0, 8'h01);
      wake(400);
      chk({got, vb}, 32'h2);
      wr(WSC_INTFLG_ADDR, 32'hFF);
      core(SLP, 8'h01);
      wake(400);
      chk(32'(got), 32'h1);
      rdc(WSC_STATUS_ADDR, 32'h18, 32'h10);
      core(CLR, 8'h01);
      core(SLP, 8'h00);
      chk(32'(OSC_DRIVER_ON), 32'h1);
      rdc(WSC_STATUS_ADDR, 32'h1B, 32'h18);
      wr(WSC_INTEN_ADDR, 32'h0);
      wr(WSC_INTFLG_ADDR, 32'hFF);
      core('0, 8'h04);
      rdc(WSC_INTFLG_ADDR, 32'hFF, 32'h04);
      wr(WSC_OPTION_ADDR, 32'h08);
      // Near time-out, so a missed clear would show
      repeat (1500) @(posedge CLK_SYS);
      core(CLR, 8'h00);
      rdc(WSC_OPTION_ADDR, 32'hFF, 32'h08);
      n0 = n_wdr;
      repeat (2000) @(posedge CLK_SYS);
      chk(32'(n_wdr - n0), 32'h0);
      for (int i = 0; i < 1500 && n_wdr == n0; i++) @(posedge CLK_SYS);
      chk(32'(n_wdr - n0), 32'h1);
      rdc(WSC_STATUS_ADDR, 32'h10, 32'h0);
      wr(WSC_OPTION_ADDR, 32'h08);
      wr(WSC_INTFLG_ADDR, 32'hFF);
      n0 = n_wdr;
      core(SLP, 8'h00);
      wake(3500);
      chk({got, 31'(n_wdr - n0)}, 32'h8000_0000);
      rdc(WSC_STATUS_ADDR, 32'h18, 32'h0);
      MASTER_CLEAR_REQ_N <= 1'h0;
      repeat (4) @(posedge CLK_SYS);
      chk(32'(DEVICE_RESET), 32'h1);
      MASTER_CLEAR_REQ_N <= 1'h1;
      give_verdict();
   end
endmodule : watchdog_sleep_wake_control_tb
`default_nettype wire
